// ===== rtl/ata_cmd_pkg.sv
// Purpose: Shared constants and types for the ATA command interpreter.
// Assumes: APB register access with 12-bit byte addresses, 40 MHz clock.
// Notes: The count and LBA task-file registers hold a previous and a current byte.
// Contract
// - Idle command sets busy, enters idle, clears busy, then interrupts.
// - Idle with nonzero count loads power-down timer in 5 ms units, enables it.
// - Idle with zero count disables automatic power-down.
// - Idle immediate does the same, ignoring all other task-file fields.
// - Media lock and unlock do nothing and complete aborted.
// - No-operation command always completes aborted.
// - Read buffer returns sector buffer contents using programmed-read protocol.
// - 28-bit DMA read moves 1 to 256 sectors; zero means 256.
// - DMA read starts at block address; drive/head gives bits 27:24.
// - On DMA read set busy, buffer a sector, then data request, clear busy.
// - DMA request stays asserted while read data is available.
// - DMA read interrupts only at full completion or unrecoverable error.
// - After success the address registers hold the last sector read.
// - On error stop at failing sector and report its address.
// - 48-bit DMA read moves 1 to 65536 sectors; zero means 65536.
// - 48-bit DMA read aborts when 8-bit transfer mode is enabled.
package ata_cmd_pkg;

  // ----------------------------------------------------------------
  // Command codes and register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_IDLE_A = 8'h97;
  localparam logic [7:0] CMD_IDLE_B = 8'hE3;
  localparam logic [7:0] CMD_IDLE_IMM_A = 8'h95;
  localparam logic [7:0] CMD_IDLE_IMM_B = 8'hE1;
  localparam logic [7:0] CMD_MEDIA_LOCK = 8'hDE;
  localparam logic [7:0] CMD_MEDIA_UNLOCK = 8'hDF;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_READ_BUF = 8'hE4;
  localparam logic [7:0] CMD_READ_DMA = 8'hC8;
  localparam logic [7:0] CMD_READ_DMA_EXT = 8'h25;
  localparam logic [11:0] OFS_COUNT = 12'h000;
  localparam logic [11:0] OFS_LBA_LOW = 12'h004;
  localparam logic [11:0] OFS_LBA_MID = 12'h008;
  localparam logic [11:0] OFS_LBA_HIGH = 12'h00C;
  localparam logic [11:0] OFS_DRIVE_HEAD = 12'h010;
  localparam logic [11:0] OFS_COMMAND = 12'h014;
  localparam logic [11:0] OFS_STATUS = 12'h018;
  localparam logic [11:0] OFS_ERROR = 12'h01C;
  localparam logic [11:0] OFS_DATA = 12'h020;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h024;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h028;
  localparam logic [11:0] OFS_CONFIG = 12'h02C;
  localparam logic [11:0] OFS_APD = 12'h030;

  // ----------------------------------------------------------------
  // Field positions, reset values and timing
  // ----------------------------------------------------------------
  localparam int STS_ERR = 0;
  localparam int STS_DRQ = 3;
  localparam int STS_BUSY = 7;
  localparam int STS_IDLE = 8;
  localparam int STS_STANDBY = 9;
  localparam int STS_APD_EN = 10;
  localparam int ERR_ABORT = 2;
  localparam int ERR_MEDIA = 6;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_APD = 2;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h7;
  localparam int SECTOR_WORDS = 256;
  localparam int APD_UNIT_MS = 5;
  localparam int CLOCK_HZ = 40_000_000;
  localparam int APD_UNIT_CYCLES = CLOCK_HZ / 1000 * APD_UNIT_MS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_IDLE_CMD, S_ABORT, S_PIO, S_FETCH, S_XFER
  } seq_state_type;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] lba_low;
    logic [15:0] lba_mid;
    logic [15:0] lba_high;
    logic [7:0] drive_head;
  } task_file_type;

  typedef struct packed {
    seq_state_type state;
    task_file_type tf;
    logic busy;
    logic data_request_flag;
    logic err_abort;
    logic err_media;
    logic idle_mode;
    logic standby;
    logic apd_en;
    logic timer_cmd;
    logic ext;
    logic eight_bit;
    logic [7:0] apd_reload;
    logic [7:0] apd_units;
    logic [31:0] apd_presc;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [16:0] remaining;
    logic [47:0] cur_lba;
    logic [8:0] word_idx;
    logic [8:0] fill_idx;
    logic dma_req;
    logic [15:0] dma_data;
    logic media_rd;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic intrq;
    logic [2:0] rs_sync;
    logic rs_f;
    logic [2:0] ack_sync;
    logic ack_f;
  } dev_state_type;

endpackage

// ===== rtl/ata_cmd_dev.sv
// Purpose: Device-side decoder and executor for idle, abort, buffer and DMA
//          read commands, with an APB register window and DMA pins.
// Assumes: Media words arrive on the same clock; DMA pins are asynchronous.
// Notes: One whole sector is buffered before the DMA request rises.
`timescale 1ns/1ps
module ata_cmd_dev #(
  parameter int APD_UNIT_CYCLES = ata_cmd_pkg::APD_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Interrupt
  output logic intrq_out,
  // DMA pins
  output logic dma_request_out,
  output logic [15:0] dma_data_out,
  input wire logic dma_ack_n_in,
  input wire logic read_strobe_n_in,
  // Media read port
  output logic media_rd_out,
  output logic [47:0] media_lba_out,
  input wire logic media_valid_in,
  input wire logic [15:0] media_word_in,
  input wire logic media_err_in
);
  import ata_cmd_pkg::*;

  // ----------------------------------------------------------------
  // State and sector buffer
  // ----------------------------------------------------------------
  dev_state_type r;
  dev_state_type n;
  logic [15:0] sector_buf [SECTOR_WORDS];
  logic setup;
  logic access;
  logic cmd_wr;
  logic strobe_done;

  assign setup = psel_in && !penable_in;
  assign access = psel_in && penable_in && r.pready;
  assign cmd_wr = access && pwrite_in && paddr_in == OFS_COMMAND &&
                  r.state == S_IDLE && !r.busy;
  // Strobe release, filtered, counted only while the host acknowledges.
  assign strobe_done = r.rs_sync[1] && r.rs_sync[2] && !r.rs_f &&
                       !r.ack_f;

  // Media words fill the buffer; no reset is needed on storage.
  always_ff @(posedge clock_in)
  begin
    if (r.state == S_FETCH && media_valid_in)
    begin
      sector_buf[r.fill_idx[7:0]] <= media_word_in;
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [2:0] ev;
    logic [2:0] clr;
    logic [47:0] lba;
    ev = 3'h0;
    clr = 3'h0;
    lba = 48'h0000_0000_0000;
    n = r;
    n.media_rd = 1'b0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;

    // Pin synchronisers; the first stage feeds only the second.
    n.rs_sync = {r.rs_sync[1:0], read_strobe_n_in};
    n.ack_sync = {r.ack_sync[1:0], dma_ack_n_in};
    if (r.rs_sync[1] == r.rs_sync[2])
    begin
      n.rs_f = r.rs_sync[2];
    end
    if (r.ack_sync[1] == r.ack_sync[2])
    begin
      n.ack_f = r.ack_sync[2];
    end

    // APB read data is prepared in the setup cycle.
    if (setup)
    begin
      n.pready = 1'b1;
      n.prdata = 32'h0000_0000;
      case (paddr_in)
        OFS_COUNT: n.prdata = {16'h0000, r.tf.count};
        OFS_LBA_LOW: n.prdata = {16'h0000, r.tf.lba_low};
        OFS_LBA_MID: n.prdata = {16'h0000, r.tf.lba_mid};
        OFS_LBA_HIGH: n.prdata = {16'h0000, r.tf.lba_high};
        OFS_DRIVE_HEAD: n.prdata = {24'h00_0000, r.tf.drive_head};
        OFS_COMMAND: n.prdata = 32'h0000_0000;
        OFS_STATUS:
        begin
          n.prdata[STS_ERR] = r.err_abort || r.err_media;
          n.prdata[STS_DRQ] = r.data_request_flag;
          n.prdata[STS_BUSY] = r.busy;
          n.prdata[STS_IDLE] = r.idle_mode;
          n.prdata[STS_STANDBY] = r.standby;
          n.prdata[STS_APD_EN] = r.apd_en;
        end
        OFS_ERROR:
        begin
          n.prdata[ERR_ABORT] = r.err_abort;
          n.prdata[ERR_MEDIA] = r.err_media;
        end
        OFS_DATA:
        begin
          if (r.state == S_PIO)
          begin
            n.prdata = {16'h0000, sector_buf[r.word_idx[7:0]]};
          end
        end
        OFS_IRQ_STATUS: n.prdata = {29'h0000_0000, r.irq_status};
        OFS_IRQ_MASK: n.prdata = {29'h0000_0000, r.irq_mask};
        OFS_CONFIG: n.prdata = {31'h0000_0000, r.eight_bit};
        OFS_APD: n.prdata = {24'h00_0000, r.apd_units};
        default: n.pslverr = 1'b1;
      endcase
    end

    // Writes and read side effects happen in the access cycle.
    if (access && pwrite_in)
    begin
      if (r.state == S_IDLE && !r.busy)
      begin
        case (paddr_in)
          OFS_COUNT: n.tf.count = {r.tf.count[7:0], pwdata_in[7:0]};
          OFS_LBA_LOW:
            n.tf.lba_low = {r.tf.lba_low[7:0], pwdata_in[7:0]};
          OFS_LBA_MID:
            n.tf.lba_mid = {r.tf.lba_mid[7:0], pwdata_in[7:0]};
          OFS_LBA_HIGH:
            n.tf.lba_high = {r.tf.lba_high[7:0], pwdata_in[7:0]};
          OFS_DRIVE_HEAD: n.tf.drive_head = pwdata_in[7:0];
          default: n.tf = r.tf;
        endcase
      end
      case (paddr_in)
        OFS_IRQ_STATUS: clr = pwdata_in[2:0];
        OFS_IRQ_MASK: n.irq_mask = pwdata_in[2:0];
        OFS_CONFIG: n.eight_bit = pwdata_in[0];
        default: n.irq_mask = r.irq_mask;
      endcase
    end
    if (access && !pwrite_in && paddr_in == OFS_DATA && r.state == S_PIO)
    begin
      n.word_idx = r.word_idx + 9'h001;
    end

    // Automatic power-down timer runs only while the device is idle.
    if (r.state == S_IDLE && !r.busy && r.idle_mode && r.apd_en)
    begin
      if (r.apd_presc == 32'(APD_UNIT_CYCLES - 1))
      begin
        n.apd_presc = 32'h0000_0000;
        n.apd_units = r.apd_units - 8'h01;
        if (r.apd_units == 8'h01)
        begin
          n.idle_mode = 1'b0;
          n.standby = 1'b1;
          ev[IRQ_APD] = 1'b1;
        end
      end
      else
      begin
        n.apd_presc = r.apd_presc + 32'h0000_0001;
      end
    end

    // Command decode.
    if (cmd_wr)
    begin
      n.busy = 1'b1;
      n.err_abort = 1'b0;
      n.err_media = 1'b0;
      n.timer_cmd = 1'b0;
      n.ext = pwdata_in[7:0] == CMD_READ_DMA_EXT;
      n.apd_presc = 32'h0000_0000;
      n.apd_units = r.apd_reload;
      case (pwdata_in[7:0])
        CMD_IDLE_A, CMD_IDLE_B:
        begin
          n.timer_cmd = 1'b1;
          n.state = S_IDLE_CMD;
        end
        CMD_IDLE_IMM_A, CMD_IDLE_IMM_B: n.state = S_IDLE_CMD;
        CMD_MEDIA_LOCK, CMD_MEDIA_UNLOCK: n.state = S_ABORT;
        CMD_NOP: n.state = S_ABORT;
        CMD_READ_BUF:
        begin
          n.state = S_PIO;
          n.word_idx = 9'h000;
        end
        CMD_READ_DMA:
        begin
          n.remaining = (r.tf.count[7:0] == 8'h00) ? 17'h0_0100 :
                        {9'h000, r.tf.count[7:0]};
          n.cur_lba = {20'h0_0000, r.tf.drive_head[3:0], r.tf.lba_high[7:0],
                       r.tf.lba_mid[7:0], r.tf.lba_low[7:0]};
          n.state = S_FETCH;
          n.media_rd = 1'b1;
          n.fill_idx = 9'h000;
        end
        CMD_READ_DMA_EXT:
        begin
          if (r.eight_bit)
          begin
            n.state = S_ABORT;
          end
          else
          begin
            n.remaining = (r.tf.count == 16'h0000) ? 17'h1_0000 :
                          {1'b0, r.tf.count};
            n.cur_lba = {r.tf.lba_high[15:8], r.tf.lba_mid[15:8],
                         r.tf.lba_low[15:8], r.tf.lba_high[7:0],
                         r.tf.lba_mid[7:0], r.tf.lba_low[7:0]};
            n.state = S_FETCH;
            n.media_rd = 1'b1;
            n.fill_idx = 9'h000;
          end
        end
        default: n.state = S_ABORT;
      endcase
    end

    // Sequencer.
    lba = r.cur_lba;
    case (r.state)
      S_IDLE: n.state = n.state;
      S_IDLE_CMD:
      begin
        n.busy = 1'b0;
        n.idle_mode = 1'b1;
        n.standby = 1'b0;
        ev[IRQ_DONE] = 1'b1;
        if (r.timer_cmd)
        begin
          n.apd_en = r.tf.count[7:0] != 8'h00;
          n.apd_reload = r.tf.count[7:0];
          n.apd_units = r.tf.count[7:0];
        end
        n.state = S_IDLE;
      end
      S_ABORT:
      begin
        n.busy = 1'b0;
        n.err_abort = 1'b1;
        ev[IRQ_DONE] = 1'b1;
        ev[IRQ_ERR] = 1'b1;
        n.state = S_IDLE;
      end
      S_PIO:
      begin
        if (r.busy)
        begin
          n.busy = 1'b0;
          n.data_request_flag = 1'b1;
          ev[IRQ_DONE] = 1'b1;
        end
        else if (r.word_idx == 9'(SECTOR_WORDS))
        begin
          n.data_request_flag = 1'b0;
          n.state = S_IDLE;
        end
      end
      S_FETCH:
      begin
        if (media_err_in)
        begin
          n.busy = 1'b0;
          n.err_media = 1'b1;
          ev[IRQ_ERR] = 1'b1;
          ev[IRQ_DONE] = 1'b1;
          n.state = S_IDLE;
        end
        else if (media_valid_in)
        begin
          n.fill_idx = r.fill_idx + 9'h001;
          if (r.fill_idx == 9'(SECTOR_WORDS - 1))
          begin
            n.busy = 1'b0;
            n.data_request_flag = 1'b1;
            n.dma_req = 1'b1;
            n.word_idx = 9'h000;
            n.state = S_XFER;
          end
        end
      end
      S_XFER:
      begin
        if (strobe_done)
        begin
          n.word_idx = r.word_idx + 9'h001;
          if (r.word_idx == 9'(SECTOR_WORDS - 1))
          begin
            n.dma_req = 1'b0;
            n.data_request_flag = 1'b0;
            n.remaining = r.remaining - 17'h0_0001;
            if (r.remaining == 17'h0_0001)
            begin
              ev[IRQ_DONE] = 1'b1;
              n.state = S_IDLE;
            end
            else
            begin
              n.busy = 1'b1;
              n.cur_lba = r.cur_lba + 48'h0000_0000_0001;
              n.media_rd = 1'b1;
              n.fill_idx = 9'h000;
              n.state = S_FETCH;
            end
          end
        end
      end
      default: n.state = S_IDLE;
    endcase

    // Address write-back of last or failing sector.
    if ((r.state == S_FETCH || r.state == S_XFER) && n.state == S_IDLE)
    begin
      if (r.ext)
      begin
        n.tf.lba_low = {lba[31:24], lba[7:0]};
        n.tf.lba_mid = {lba[39:32], lba[15:8]};
        n.tf.lba_high = {lba[47:40], lba[23:16]};
      end
      else
      begin
        n.tf.lba_low[7:0] = lba[7:0];
        n.tf.lba_mid[7:0] = lba[15:8];
        n.tf.lba_high[7:0] = lba[23:16];
        n.tf.drive_head[3:0] = lba[27:24];
      end
    end

    n.dma_data = sector_buf[n.word_idx[7:0]];
    // A new event beats a clear in the same cycle.
    n.irq_status = (r.irq_status & ~clr) | ev;
    n.intrq = |(n.irq_status & n.irq_mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      r <= '0;
      r.state <= S_IDLE;
      r.irq_mask <= IRQ_MASK_RESET;
      r.rs_sync <= 3'h7;
      r.rs_f <= 1'b1;
      r.ack_sync <= 3'h7;
      r.ack_f <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  assign prdata_out = r.prdata;
  assign pready_out = r.pready;
  assign pslverr_out = r.pslverr;
  assign intrq_out = r.intrq;
  assign dma_request_out = r.dma_req;
  assign dma_data_out = r.dma_data;
  assign media_rd_out = r.media_rd;
  assign media_lba_out = r.cur_lba;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence idle_issue;
    cmd_wr && (pwdata_in[7:0] == CMD_IDLE_A ||
               pwdata_in[7:0] == CMD_IDLE_B);
  endsequence
  sequence idle_finish;
    r.busy ##1 (!r.busy && r.idle_mode && r.irq_status[IRQ_DONE]);
  endsequence

  AST_IDLE_SEQ: assert property (idle_issue |=> idle_finish)
    else $error("idle command did not complete in order");
  AST_APD_OFF: assert property ((idle_issue and
    r.tf.count[7:0] == 8'h00) |-> ##2 !r.apd_en)
    else $error("zero count left power-down enabled");
  AST_APD_LOAD: assert property ((idle_issue and
    r.tf.count[7:0] != 8'h00) |-> ##2
    (r.apd_en && r.apd_units == $past(r.tf.count[7:0], 2)))
    else $error("power-down timer not loaded");
  AST_IMM_IDLE: assert property ((cmd_wr && pwdata_in[7:0] ==
    CMD_IDLE_IMM_A) |=> r.busy ##1 (!r.busy && r.idle_mode))
    else $error("idle immediate failed");
  AST_ABORT: assert property ((cmd_wr && (pwdata_in[7:0] == CMD_NOP ||
    pwdata_in[7:0] == CMD_MEDIA_LOCK)) |-> ##2
    (r.err_abort && !r.busy && r.irq_status[IRQ_ERR]))
    else $error("abort not reported");
  AST_EXT_8BIT: assert property ((cmd_wr && r.eight_bit &&
    pwdata_in[7:0] == CMD_READ_DMA_EXT) |-> ##2 r.err_abort)
    else $error("8-bit mode did not abort 48-bit read");
  AST_COUNT_ZERO: assert property ((cmd_wr && r.tf.count[7:0] == 8'h00 &&
    pwdata_in[7:0] == CMD_READ_DMA) |=> r.remaining == 17'h0_0100)
    else $error("zero count did not mean 256 sectors");
  AST_REQ_DATA: assert property (r.dma_req |->
    (r.state == S_XFER && r.word_idx < 9'(SECTOR_WORDS)))
    else $error("DMA request without data");
  AST_NO_MID_IRQ: assert property ((r.state == S_XFER &&
    r.remaining > 17'h0_0001) |=> !$rose(r.irq_status[IRQ_DONE]))
    else $error("interrupt raised mid transfer");
  AST_PIO_DRQ: assert property ((cmd_wr && pwdata_in[7:0] ==
    CMD_READ_BUF) |-> ##2 (r.data_request_flag && !r.busy))
    else $error("read buffer did not raise data request");

endmodule

// ===== verification/dma_host_model.sv
// Purpose: Host-side DMA reader that drains words from the device.
// Assumes: Strobe phases of six cycles or more pass the pin filter.
// Notes: Words are summed with a position weight so order matters.
`timescale 1ns/1ps
module dma_host_model (
  // Clock and control
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic [3:0] stall_in,
  // DMA pins
  input wire logic dma_request_in,
  input wire logic [15:0] dma_data_in,
  output logic dma_ack_n_out,
  output logic read_strobe_n_out,
  // Results
  output logic [31:0] words_out,
  output logic [31:0] sum_out
);
  initial
  begin
    dma_ack_n_out = 1'b1;
    read_strobe_n_out = 1'b1;
    words_out = 32'h0000_0000;
    sum_out = 32'h0000_0000;
    forever
    begin
      @(posedge clock_in);
      dma_ack_n_out <= ~enable_in;
      if (enable_in && !rst_in && dma_request_in === 1'b1)
      begin
        // Stall stretches both strobe phases.
        read_strobe_n_out <= 1'b0;
        repeat (6 + stall_in) @(posedge clock_in);
        sum_out <= sum_out + (words_out + 1) * {16'h0000, dma_data_in};
        words_out <= words_out + 1;
        read_strobe_n_out <= 1'b1;
        repeat (6 + stall_in) @(posedge clock_in);
      end
    end
  end
endmodule

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the ATA command interpreter.
// Assumes: Power-down unit shortened to 4 cycles; media is modelled here.
// Notes: Media words are {sector low byte, word index}.
`timescale 1ns/1ps
module tb_top;
  import ata_cmd_pkg::*;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic clock_in, rst_in, psel, penable, pwrite, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, words, sum;
  logic pready, pslverr, intrq, dreq, ack_n, strobe_n;
  logic [15:0] ddata, mword;
  logic mrd, mvalid, merr, host_en, mid_irq;
  logic [3:0] stall;
  logic [47:0] mlba;
  logic [27:0] err_lba;
  logic [47:0] fetched[$];
  int n_fail, tests_run;

  ata_cmd_dev #(.APD_UNIT_CYCLES(4)) u_ata_cmd_dev (
    .clock_in(clock_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .intrq_out(intrq), .dma_request_out(dreq),
    .dma_data_out(ddata), .dma_ack_n_in(ack_n),
    .read_strobe_n_in(strobe_n), .media_rd_out(mrd),
    .media_lba_out(mlba), .media_valid_in(mvalid),
    .media_word_in(mword), .media_err_in(merr));

  dma_host_model u_dma_host_model (
    .clock_in(clock_in), .rst_in(rst_in), .enable_in(host_en),
    .stall_in(stall), .dma_request_in(dreq), .dma_data_in(ddata),
    .dma_ack_n_out(ack_n), .read_strobe_n_out(strobe_n),
    .words_out(words), .sum_out(sum));

  initial
  begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // Media answers each fetch with a full sector or an error pulse.
  initial
  begin
    mvalid = 1'b0;
    merr = 1'b0;
    mword = 16'h0000;
    mid_irq = 1'b0;
    forever
    begin
      @(posedge clock_in);
      if (mrd === 1'b1)
      begin
        fetched.push_back(mlba);
        mid_irq = mid_irq | intrq;
        repeat (2) @(posedge clock_in);
        if (fetched[$][27:0] === err_lba)
        begin
          merr <= 1'b1;
          @(posedge clock_in);
          merr <= 1'b0;
        end
        else
        begin
          for (int i = 0; i < SECTOR_WORDS; i++)
          begin
            mvalid <= 1'b1;
            mword <= {fetched[$][7:0], i[7:0]};
            @(posedge clock_in);
          end
          mvalid <= 1'b0;
        end
      end
    end
  end
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do
    begin
      @(posedge clock_in);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) n_fail++;
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_irq(input int b);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, OFS_IRQ_STATUS, 32'h0);
      n++;
    end
    while (rd[b] !== 1'b1 && n < 4000);
    chk("irq bit", 32'h1, {31'h0, rd[b]});
  endtask

  task automatic run_dma(input logic [7:0] cmd, input logic [47:0] lba,
    input int n);
    logic [31:0] w0, exp_sum, k;
    w0 = words;
    exp_sum = sum;
    k = w0;
    for (int j = 0; j < n; j++)
      for (int i = 0; i < 256; i++)
      begin
        k++;
        exp_sum = exp_sum + k * {16'h0, lba[7:0] + 8'(j), i[7:0]};
      end
    fetched.delete();
    mid_irq = 1'b0;
    host_en <= 1'b1;
    apb(1'b1, OFS_COMMAND, {24'h0, cmd});
    wait_irq(IRQ_DONE);
    host_en <= 1'b0;
    chk("words", w0 + 32'(n) * 256, words);
    chk("data", exp_sum, sum);
    chk("fetches", 32'(n), 32'(fetched.size()));
    chk("lba lo", {8'h0, lba[23:0]}, {8'h0, fetched[0][23:0]});
    chk("lba hi", {8'h0, lba[47:24]}, {8'h0, fetched[0][47:24]});
    chk("early irq", 32'h0, {31'h0, mid_irq});
    apb(1'b0, OFS_LBA_LOW, 32'h0);
    chk("final lba", {24'h0, lba[7:0] + 8'(n - 1)}, rd & 32'hFF);
    apb(1'b1, OFS_IRQ_STATUS, 32'h7);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_mask();
    apb(1'b0, OFS_IRQ_MASK, 32'h0);
    chk("mask reset", 32'h7, rd & 32'h7);
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    apb(1'b1, OFS_COMMAND, {24'h0, CMD_NOP});
    wait_irq(IRQ_ERR);
    chk("masked line", 32'h0, {31'h0, intrq});
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clock_in);
    chk("unmasked line", 32'h1, {31'h0, intrq});
    apb(1'b1, OFS_IRQ_STATUS, 32'h7);
    repeat (2) @(posedge clock_in);
    chk("cleared line", 32'h0, {31'h0, intrq});
    apb(1'b1, OFS_IRQ_MASK, 32'h7);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, perr});
    chk("unmapped data", 32'h0, rd);
    $display("test mask done");
  endtask

  task automatic t_idle();
    apb(1'b1, OFS_COUNT, 32'h40);
    apb(1'b1, OFS_COMMAND, {24'h0, CMD_IDLE_B});
    wait_irq(IRQ_DONE);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("idle status", 32'h500, rd & 32'h580);
    apb(1'b1, OFS_IRQ_STATUS, 32'h7);
    wait_irq(IRQ_APD);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("standby", 32'h200, rd & 32'h300);
    apb(1'b1, OFS_IRQ_STATUS, 32'h7);
    $display("test idle done");
  endtask

  task automatic t_codes();
    logic [7:0] c [7] = '{CMD_IDLE_A, CMD_IDLE_IMM_A, CMD_IDLE_IMM_B,
      CMD_NOP, CMD_MEDIA_LOCK, CMD_MEDIA_UNLOCK, 8'h5A};
    logic [31:0] s;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, OFS_COUNT, (i == 1 || i == 2) ? 32'h20 : 32'h0);
      apb(1'b1, OFS_COMMAND, {24'h0, c[i]});
      wait_irq(IRQ_DONE);
      s = rd & 32'h7;
      if (i < 3)
      begin
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("idle code", 32'h100, rd & 32'h589);
        chk("idle irq", 32'h1, s);
      end
      else
      begin
        apb(1'b0, OFS_ERROR, 32'h0);
        chk("abort code", 32'h4, rd & 32'h44);
        chk("abort irq", 32'h3, s);
      end
      apb(1'b1, OFS_IRQ_STATUS, 32'h7);
    end
    $display("test codes done");
  endtask

  task automatic t_dma28();
    stall <= 4'h3;
    apb(1'b1, OFS_COUNT, 32'h2);
    apb(1'b1, OFS_LBA_LOW, 32'h56);
    apb(1'b1, OFS_LBA_MID, 32'h34);
    apb(1'b1, OFS_LBA_HIGH, 32'h12);
    apb(1'b1, OFS_DRIVE_HEAD, 32'hE5);
    run_dma(CMD_READ_DMA, 48'h0000_0512_3456, 2);
    stall <= 4'h0;
    $display("test dma28 done");
  endtask

  task automatic t_err();
    err_lba = 28'h000_0021;
    apb(1'b1, OFS_COUNT, 32'h3);
    apb(1'b1, OFS_LBA_LOW, 32'h20);
    apb(1'b1, OFS_LBA_MID, 32'h0);
    apb(1'b1, OFS_LBA_HIGH, 32'h0);
    apb(1'b1, OFS_DRIVE_HEAD, 32'hE0);
    host_en <= 1'b1;
    apb(1'b1, OFS_COMMAND, {24'h0, CMD_READ_DMA});
    wait_irq(IRQ_ERR);
    host_en <= 1'b0;
    apb(1'b0, OFS_ERROR, 32'h0);
    chk("media err", 32'h40, rd & 32'h40);
    apb(1'b0, OFS_LBA_LOW, 32'h0);
    chk("fail lba", 32'h21, rd & 32'hFF);
    apb(1'b1, OFS_IRQ_STATUS, 32'h7);
    err_lba = '1;
    $display("test error done");
  endtask

  task automatic t_dma48();
    logic [11:0] a [8] = '{OFS_COUNT, OFS_COUNT, OFS_LBA_LOW, OFS_LBA_LOW,
      OFS_LBA_MID, OFS_LBA_MID, OFS_LBA_HIGH, OFS_LBA_HIGH};
    logic [7:0] v [8] = '{8'h00, 8'h01, 8'h01, 8'h40, 0, 0, 0, 0};
    apb(1'b1, OFS_CONFIG, 32'h1);
    apb(1'b1, OFS_COMMAND, {24'h0, CMD_READ_DMA_EXT});
    wait_irq(IRQ_ERR);
    apb(1'b0, OFS_ERROR, 32'h0);
    chk("eight bit", 32'h4, rd & 32'h4);
    apb(1'b1, OFS_IRQ_STATUS, 32'h7);
    apb(1'b1, OFS_CONFIG, 32'h0);
    for (int i = 0; i < 8; i++)
      apb(1'b1, a[i], {24'h0, v[i]});
    apb(1'b0, OFS_COUNT, 32'h0);
    chk("count pair", 32'h1, rd & 32'hFFFF);
    run_dma(CMD_READ_DMA_EXT, 48'h0000_0100_0040, 1);
    $display("test dma48 done");
  endtask

  task automatic t_rdbuf();
    apb(1'b1, OFS_COMMAND, {24'h0, CMD_READ_BUF});
    wait_irq(IRQ_DONE);
    for (int i = 0; i < 256; i++)
    begin
      apb(1'b0, OFS_DATA, 32'h0);
      chk("buffer word", {16'h0, 8'h40, i[7:0]}, rd & 32'hFFFF);
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("drq after", 32'h0, rd & 32'h88);
    $display("test read buffer done");
  endtask
  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (80000) @(posedge clock_in);
    n_fail++;
    print_verdict();
  end

  initial
  begin
    rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    host_en = 1'b0;
    stall = 4'h0;
    err_lba = '1;
    n_fail = 0;
    tests_run = 0;
    repeat (16) @(posedge clock_in);
    rst_in <= 1'b0;
    t_mask();
    t_idle();
    t_codes();
    t_dma28();
    t_err();
    t_dma48();
    t_rdbuf();
    print_verdict();
  end
endmodule
